// File: hw/host_end.sv
`timescale 1ns/10ps
// =====================================================================
// master end: makes bit clock and strobe, collects slot words
module host_end #(
  parameter int WARMUP_CYC = mic_link_pkg::WARMUP_CYC
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic         run_i,
  output logic [23:0]       sample_o,
  output logic              sample_right_o,
  output logic              sample_valid_o,
  output logic              warm_o,
  mic_link_if.host          lnk
);
  localparam int WB = mic_link_pkg::WORD_BITS;

  typedef struct packed {
    logic [mic_link_pkg::PH_W-1:0]    ph;
    logic                             bclk;
    logic                             ws;
    logic [mic_link_pkg::FRAME_W-1:0] pos;
    logic                             din_s1;
    logic                             din_s2;
    logic [WB-1:0]                    shift;
    logic [mic_link_pkg::WARM_W-1:0]  warm_cnt;
    logic                             warm;
    logic [WB-1:0]                    smp;
    logic                             smp_right;
    logic                             smp_valid;
  } host_state_type;

  host_state_type st_r;
  host_state_type st_nxt;
  logic [mic_link_pkg::FRAME_W-1:0] pos_inc;
  logic [mic_link_pkg::FRAME_W-2:0] bit_idx;

  assign pos_inc = st_r.pos + 1'b1;
  assign bit_idx = st_r.pos[mic_link_pkg::FRAME_W-2:0];

  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.din_s1    = lnk.host_serial_input_line;
    st_nxt.din_s2    = st_r.din_s1;
    st_nxt.smp_valid = 1'b0;
    if (!run_i)
    begin
      // stopped clock sends the microphone to sleep
      st_nxt.ph       = '0;
      st_nxt.bclk     = 1'b0;
      st_nxt.ws       = 1'b0;
      st_nxt.pos      = '1;
      st_nxt.warm_cnt = '0;
      st_nxt.warm     = 1'b0;
    end
    else
    begin
      st_nxt.ph = (st_r.ph == mic_link_pkg::PH_W'(mic_link_pkg::PH_LAST)) ? '0 : st_r.ph + 1'b1;
      if (st_r.ph == mic_link_pkg::PH_W'(mic_link_pkg::PH_FALL))
      begin
        st_nxt.bclk = 1'b0;
        st_nxt.pos  = pos_inc;
        st_nxt.ws   = pos_inc[mic_link_pkg::FRAME_W-1];
      end
      if (st_r.ph == mic_link_pkg::PH_W'(mic_link_pkg::PH_LAST))
      begin
        st_nxt.bclk = 1'b1;
        // sync output here holds the line as it stood at the falling edge
        if (bit_idx >= 5'h01 && bit_idx <= 5'(WB))
          st_nxt.shift = {st_r.shift[WB-2:0], st_r.din_s2};
        if (bit_idx == 5'(WB))
        begin
          st_nxt.smp       = {st_r.shift[WB-2:0], st_r.din_s2};
          st_nxt.smp_right = st_r.pos[mic_link_pkg::FRAME_W-1];
          st_nxt.smp_valid = st_r.warm;
        end
      end
      if (st_r.warm_cnt >= mic_link_pkg::WARM_W'(WARMUP_CYC - 1))
        st_nxt.warm = 1'b1;
      else
        st_nxt.warm_cnt = st_r.warm_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_r     <= '0;
      st_r.pos <= 6'h3F;
    end
    else if (ce_i)
      st_r <= st_nxt;
  end

  assign lnk.bclk       = st_r.bclk;
  assign lnk.ws         = st_r.ws;
  assign sample_o       = st_r.smp;
  assign sample_right_o = st_r.smp_right;
  assign sample_valid_o = st_r.smp_valid;
  assign warm_o         = st_r.warm;
endmodule : host_end

// File: hw/mic_end.sv
`timescale 1ns/10ps
// Functional notes
// - decimate one-bit density stream by 64 to PCM
// - select high: drive data only while strobe high; here the enable follows the strobe half a bit late
// - select low: drive data only while strobe low; here the enable follows the strobe half a bit late
// - opposite selects share one data line
// - fast bit clock gives active slave mode
// - slow or stopped clock: sleep, data released; here the bit-clocked enable holds its value if the clock stops in the own slot
// - unpowered: data always released; here the enable drops only after three rising bit clock edges
// - master makes strobe at bit clock over 64
// - master bit clock 1.024 to 4.096 MHz
// - 24-bit two's complement words, MSB first
// - upper 18 bits carry data, rest zero
// - master changes strobe on falling clock edge
// - MSB one bit clock after strobe change
// - launch each data bit on rising clock edge
// - output settles 50 ms after clock appears

// =====================================================================
// word buffer between decimator and link crossing
module mic_word_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
  } fifo_state_type;
  fifo_state_type st_r;
  fifo_state_type st_nxt;
  logic push;
  logic pop;

  assign in_ready_o  = (st_r.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = st_r.mem[st_r.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr] = in_data_i;
      st_nxt.wr           = (st_r.wr == PW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rd = (st_r.rd == PW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st_r <= '0;
    else if (ce_i)
      st_r <= st_nxt;
  end
endmodule : mic_word_fifo

// =====================================================================
// microphone end: decimator, mode detect, serial slave output
module mic_end #(
  parameter int SLEEP_GAP_CYC = mic_link_pkg::SLEEP_GAP_CYC,
  parameter int WARMUP_CYC    = mic_link_pkg::WARMUP_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic power_good_i,
  input  wire logic select_i,
  input  wire logic pdm_bit_i,
  input  wire logic pdm_valid_i,
  output logic      pdm_ready_o,
  output logic      active_o,
  output logic      warm_o,
  mic_link_if.mic   lnk
);
  localparam int WB = mic_link_pkg::WORD_BITS;

  typedef struct packed {
    logic                                  clk_s1;
    logic                                  clk_s2;
    logic                                  clk_s3;
    logic                                  pwr_s1;
    logic                                  pwr_s2;
    logic [mic_link_pkg::GAP_W-1:0]        gap;
    mic_link_pkg::mode_type                mode;
    logic [mic_link_pkg::WARM_W-1:0]       warm_cnt;
    logic                                  warm;
    logic [mic_link_pkg::DECIM_W-1:0]      dec_cnt;
    logic [mic_link_pkg::ONES_W-1:0]       ones;
    logic                                  hold_valid;
    logic [WB-1:0]                         hold_word;
    logic                                  pdm_rdy;
    logic                                  req_tgl;
    logic                                  ack_s1;
    logic                                  ack_s2;
    logic [WB-1:0]                         xfer_word;
  } core_state_type;

  typedef struct packed {
    logic          rst_s1;
    logic          rst_s2;
    logic          pwr_s1;
    logic          pwr_s2;
    logic          act_s1;
    logic          act_s2;
    logic          sel_s1;
    logic          sel_s2;
    logic          req_s1;
    logic          req_s2;
    logic          req_s3;
    logic          ack_tgl;
    logic [WB-1:0] next_word;
    logic          next_full;
    logic          ws_prev;
    logic [WB-1:0] shift;
    logic          data;
    logic          oe;
  } link_state_type;

  core_state_type cs_r;
  core_state_type cs_nxt;
  link_state_type ls_r;
  link_state_type ls_nxt;
  logic           fifo_in_ready;
  logic [WB-1:0]  fifo_out_data;
  logic           fifo_out_valid;
  logic           fifo_out_ready;
  logic [mic_link_pkg::ONES_W-1:0] ones_sum;
  logic signed [mic_link_pkg::PREC_BITS-1:0] pcm;

  // =====================================================================
  // core domain
  assign ones_sum = cs_r.ones + mic_link_pkg::ONES_W'(pdm_bit_i);
  // density centred at zero, scaled so a full-scale run stays in range
  assign pcm = mic_link_pkg::PREC_BITS'(signed'({1'b0, ones_sum})
               - mic_link_pkg::DENS_MID) <<< mic_link_pkg::PCM_SHIFT;
  assign fifo_out_ready = (cs_r.req_tgl == cs_r.ack_s2);

  always_comb
  begin
    cs_nxt        = cs_r;
    cs_nxt.clk_s1 = lnk.bclk;
    cs_nxt.clk_s2 = cs_r.clk_s1;
    cs_nxt.clk_s3 = cs_r.clk_s2;
    cs_nxt.pwr_s1 = power_good_i;
    cs_nxt.pwr_s2 = cs_r.pwr_s1;
    cs_nxt.ack_s1 = ls_r.ack_tgl;
    cs_nxt.ack_s2 = cs_r.ack_s1;
    // edge spacing on the core clock is the slow reference
    if (cs_r.clk_s2 && !cs_r.clk_s3)
    begin
      cs_nxt.gap = '0;
      if (cs_r.gap < mic_link_pkg::GAP_W'(mic_link_pkg::ACTIVE_GAP_CYC))
        cs_nxt.mode = mic_link_pkg::MODE_ACTIVE;
    end
    else if (cs_r.gap >= mic_link_pkg::GAP_W'(SLEEP_GAP_CYC - 1))
      cs_nxt.mode = mic_link_pkg::MODE_SLEEP;
    else
      cs_nxt.gap = cs_r.gap + 1'b1;
    if (!cs_r.pwr_s2)
      cs_nxt.mode = mic_link_pkg::MODE_SLEEP;
    // settling timer restarts on every wake
    if (cs_r.mode != mic_link_pkg::MODE_ACTIVE)
    begin
      cs_nxt.warm_cnt = '0;
      cs_nxt.warm     = 1'b0;
    end
    else if (cs_r.warm_cnt >= mic_link_pkg::WARM_W'(WARMUP_CYC - 1))
      cs_nxt.warm = 1'b1;
    else
      cs_nxt.warm_cnt = cs_r.warm_cnt + 1'b1;
    // decimator, stalled while a finished word waits for the buffer
    if (cs_r.hold_valid && fifo_in_ready)
      cs_nxt.hold_valid = 1'b0;
    if (pdm_valid_i && cs_r.pdm_rdy)
    begin
      cs_nxt.dec_cnt = cs_r.dec_cnt + 1'b1;
      cs_nxt.ones    = ones_sum;
      if (cs_r.dec_cnt == mic_link_pkg::DECIM_W'(mic_link_pkg::DECIM - 1))
      begin
        cs_nxt.ones       = '0;
        cs_nxt.hold_valid = 1'b1;
        cs_nxt.hold_word  = cs_r.warm ? {pcm, mic_link_pkg::PAD_BITS'(0)} : '0;
      end
    end
    cs_nxt.pdm_rdy = (cs_nxt.mode == mic_link_pkg::MODE_ACTIVE) && !cs_nxt.hold_valid;
    // toggle handshake: word stays put until the link side answers
    if (fifo_out_valid && fifo_out_ready)
    begin
      cs_nxt.xfer_word = fifo_out_data;
      cs_nxt.req_tgl   = !cs_r.req_tgl;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      cs_r <= '0;
    else if (ce_i)
      cs_r <= cs_nxt;
  end

  mic_word_fifo #(
    .WIDTH (WB),
    .DEPTH (mic_link_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_data_i   (cs_r.hold_word),
    .in_valid_i  (cs_r.hold_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready)
  );

  assign pdm_ready_o = cs_r.pdm_rdy;
  assign active_o    = (cs_r.mode == mic_link_pkg::MODE_ACTIVE);
  assign warm_o      = cs_r.warm;

  // =====================================================================
  // link domain, clocked by the bit clock itself
  always_comb
  begin
    ls_nxt        = ls_r;
    ls_nxt.rst_s1 = srst_i;
    ls_nxt.rst_s2 = ls_r.rst_s1;
    ls_nxt.pwr_s1 = power_good_i;
    ls_nxt.pwr_s2 = ls_r.pwr_s1;
    ls_nxt.act_s1 = (cs_r.mode == mic_link_pkg::MODE_ACTIVE);
    ls_nxt.act_s2 = ls_r.act_s1;
    ls_nxt.sel_s1 = select_i;
    ls_nxt.sel_s2 = ls_r.sel_s1;
    ls_nxt.req_s1 = cs_r.req_tgl;
    ls_nxt.req_s2 = ls_r.req_s1;
    ls_nxt.req_s3 = ls_r.req_s2;
    ls_nxt.ws_prev = lnk.ws;
    // strobe is sampled on the rising edge, mid-bit of its falling change
    if (lnk.ws != ls_r.ws_prev && lnk.ws == ls_r.sel_s2)
    begin
      ls_nxt.data      = ls_r.next_full ? ls_r.next_word[WB-1] : 1'b0;
      ls_nxt.shift     = ls_r.next_full ? {ls_r.next_word[WB-2:0], 1'b0} : '0;
      ls_nxt.next_full = 1'b0;
    end
    else
    begin
      ls_nxt.data  = ls_r.shift[WB-1];
      ls_nxt.shift = {ls_r.shift[WB-2:0], 1'b0};
    end
    // a new word arriving as the old one is taken still counts
    if (ls_r.req_s2 != ls_r.req_s3)
    begin
      ls_nxt.next_word = cs_r.xfer_word;
      ls_nxt.next_full = 1'b1;
      ls_nxt.ack_tgl   = !ls_r.ack_tgl;
    end
    // enable lags the strobe by half a bit; the first bit is already valid
    ls_nxt.oe = ls_r.pwr_s2 && ls_r.act_s2 && (lnk.ws == ls_r.sel_s2);
    if (!ls_nxt.oe)
      ls_nxt.data = 1'b0;
  end

  always_ff @(posedge lnk.bclk)
  begin
    if (ls_r.rst_s2)
    begin
      ls_r        <= '0;
      ls_r.rst_s1 <= srst_i;
      ls_r.rst_s2 <= ls_r.rst_s1;
    end
    else
      ls_r <= ls_nxt;
  end

  assign lnk.mic_data    = ls_r.data;
  assign lnk.mic_data_oe = ls_r.oe;
endmodule : mic_end

// File: hw/mic_link_if.sv
`timescale 1ns/10ps
interface mic_link_if;
  logic bclk;
  logic ws;
  logic mic_data;
  logic mic_data_oe;
  logic host_serial_input_line;
  // board pull-down keeps the released line low
  assign host_serial_input_line = mic_data_oe ? mic_data : 1'b0;
  modport mic (
    input  bclk,
    input  ws,
    output mic_data,
    output mic_data_oe
  );
  modport host (
    output bclk,
    output ws,
    input  host_serial_input_line
  );
endinterface : mic_link_if

// File: hw/mic_link_pkg.sv
package mic_link_pkg;
  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int ACTIVE_PERIOD_NS = 1000;
  localparam int ACTIVE_GAP_CYC   = ACTIVE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLEEP_PERIOD_NS  = 1000000;
  localparam int SLEEP_GAP_CYC    = SLEEP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WARMUP_MS        = 50;
  localparam int WARMUP_CYC       = WARMUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BCLK_PERIOD_NS   = 400;
  localparam int BCLK_HALF_CYC    = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int PH_FALL          = BCLK_HALF_CYC - 1;
  localparam int PH_LAST          = 2 * BCLK_HALF_CYC - 1;
  // =====================================================================
  // widths and formats
  localparam int GAP_W      = 14;
  localparam int WARM_W     = 19;
  localparam int PH_W       = 2;
  localparam int DECIM      = 64;
  localparam int DECIM_W    = 6;
  localparam int ONES_W     = 7;
  localparam int DENS_MID   = 32;
  localparam int PCM_SHIFT  = 11;
  localparam int WORD_BITS  = 24;
  localparam int PREC_BITS  = 18;
  localparam int PAD_BITS   = WORD_BITS - PREC_BITS;
  localparam int FRAME_W    = 6;
  localparam int FIFO_DEPTH = 4;
  // =====================================================================
  // modes
  typedef enum logic [0:0] {
    MODE_SLEEP  = 1'b0,
    MODE_ACTIVE = 1'b1
  } mode_type;
endpackage : mic_link_pkg

// File: verif/mic_serial_audio_output_monitor.sv
`timescale 1ns/10ps
module mic_serial_audio_output_monitor (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic bclk,
  input wire logic ws,
  input wire logic mic_data,
  input wire logic mic_data_oe,
  input wire logic host_serial_input_line,
  input wire logic select_i,
  input wire logic power_good_i
);
  // =====================================================================
  // helper counters
  logic [6:0] low_cnt_r;
  logic [5:0] fall_cnt_r;
  logic [4:0] off_cnt_r;
  logic       framed_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // a bit clock low for three samples means stopped; the frame restarts at slot start
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      low_cnt_r  <= 7'h00;
      fall_cnt_r <= 6'h00;
      off_cnt_r  <= 5'h00;
      framed_r   <= 1'b0;
    end
    else
    begin
      low_cnt_r <= bclk ? 7'h00 : low_cnt_r + 7'(low_cnt_r != 7'h7F);
      off_cnt_r <= power_good_i ? 5'h00 : off_cnt_r + 5'(off_cnt_r != 5'h1F);
      framed_r  <= framed_r | $changed(ws);
      if (low_cnt_r >= 7'h03 || $changed(ws))
        fall_cnt_r <= 6'h00;
      else if ($fell(bclk))
        fall_cnt_r <= fall_cnt_r + 6'h01;
    end
  end

  // =====================================================================
  // properties
  property p_ws_fall;
    $changed(ws) |-> $fell(bclk);
  endproperty
  property p_bclk_rate;
    $rose(bclk) |=> ##1 !bclk ##1 !bclk;
  endproperty
  property p_frame;
    $changed(ws) && framed_r |-> fall_cnt_r == 6'h1F;
  endproperty
  // data is let go half a bit after the strobe leaves the own slot
  property p_oe_slot;
    mic_data_oe && ws != select_i |-> ws != $past(ws, 2);
  endproperty
  property p_oe_fall;
    $fell(mic_data_oe) && power_good_i |-> ws != select_i && ws == $past(ws, 2) && ws != $past(ws, 3);
  endproperty
  property p_launch;
    $changed(mic_data) || $changed(mic_data_oe) |-> $rose(bclk);
  endproperty
  property p_power_off;
    off_cnt_r == 5'h1F |-> !mic_data_oe;
  endproperty
  property p_sleep_off;
    low_cnt_r == 7'h7F |-> !mic_data_oe && !host_serial_input_line;
  endproperty

  a_ws_fall: assert property (p_ws_fall) else $error("strobe moved off a falling clock");
  a_bclk_rate: assert property (p_bclk_rate) else $error("bit clock period wrong");
  a_frame: assert property (p_frame) else $error("strobe half frame not 32 bits");
  a_oe_slot: assert property (p_oe_slot) else $error("data driven outside own slot");
  a_oe_fall: assert property (p_oe_fall) else $error("data released at wrong moment");
  a_launch: assert property (p_launch) else $error("data changed off a rising clock");
  a_power_off: assert property (p_power_off) else $error("data driven while unpowered");
  a_sleep_off: assert property (p_sleep_off) else $error("data driven while clock stopped");

  c_frame: cover property ($changed(ws) && framed_r);
  c_own: cover property ($rose(mic_data_oe));
  c_power: cover property (off_cnt_r == 5'h1F);
  c_sleep: cover property (low_cnt_r == 7'h7F);
endmodule : mic_serial_audio_output_monitor

// File: verif/test_mic_serial_audio_output.sv
`timescale 1ns/10ps
module test_mic_serial_audio_output;
  // =====================================================================
  // pins and instances
  logic        core_clk_i;
  logic        srst_i;
  logic        mic_srst;
  logic        power_good_i;
  logic        select_i;
  logic        pdm_bit_i;
  logic        pdm_valid_i;
  logic        pdm_ready_o;
  logic        active_o;
  logic        mic_warm;
  logic        run_i;
  logic [23:0] sample_o;
  logic        sample_right_o;
  logic        sample_valid_o;
  logic        host_warm;
  int          n_mismatch;
  int          checked;
  int          dens = 0;
  int          acc_k = 0;

  mic_link_if lnk_if ();

  // mic reset outlasts the host one: its link side needs bit clock edges to clear
  mic_end #(.SLEEP_GAP_CYC(50), .WARMUP_CYC(20)) i_mic_end (
    .core_clk_i(core_clk_i), .srst_i(mic_srst), .ce_i(1'b1), .power_good_i(power_good_i),
    .select_i(select_i), .pdm_bit_i(pdm_bit_i), .pdm_valid_i(pdm_valid_i), .pdm_ready_o(pdm_ready_o),
    .active_o(active_o), .warm_o(mic_warm), .lnk(lnk_if.mic));
  host_end #(.WARMUP_CYC(20)) i_host_end (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(1'b1), .run_i(run_i), .sample_o(sample_o),
    .sample_right_o(sample_right_o), .sample_valid_o(sample_valid_o), .warm_o(host_warm), .lnk(lnk_if.host));
  mic_serial_audio_output_monitor i_mic_serial_audio_output_monitor (
    .core_clk_i(core_clk_i), .srst_i(mic_srst), .bclk(lnk_if.bclk), .ws(lnk_if.ws),
    .mic_data(lnk_if.mic_data), .mic_data_oe(lnk_if.mic_data_oe),
    .host_serial_input_line(lnk_if.host_serial_input_line), .select_i(select_i), .power_good_i(power_good_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #(mic_link_pkg::CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  end

  // periodic pattern: any 64 accepted bits hold exactly dens ones, whatever the alignment
  always @(posedge core_clk_i)
    if (pdm_valid_i === 1'b1 && pdm_ready_o === 1'b1) acc_k <= acc_k + 1;
  always @(negedge core_clk_i)
    pdm_bit_i <= (acc_k % mic_link_pkg::DECIM) < dens;

  // =====================================================================
  // shared tasks
  task check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [23:0] exp_word(input int n);
    logic [23:0] v;
    v = 24'((n - mic_link_pkg::DENS_MID) * (1 << mic_link_pkg::PCM_SHIFT));
    return {v[17:0], 6'h00};
  endfunction : exp_word

  task get_sample(output logic [23:0] w, output logic r);
    int i;
    for (i = 0; i < 600; i++)
    begin
      @(negedge core_clk_i);
      if (sample_valid_o === 1'b1) break;
    end
    check(24'(sample_valid_o), 24'h000001);
    w = sample_o;
    r = sample_right_o;
  endtask : get_sample

  // words lag by fifo depth plus holding stages, hence the skipped samples
  task slot_run(input int n, input logic [23:0] own, input int skip);
    logic [23:0] w;
    logic        r;
    int          i;
    dens = n;
    for (i = 0; i < skip + 4; i++)
    begin
      get_sample(w, r);
      if (i < skip) continue;
      if (r === select_i) check(w, own);
      else check(w, 24'h000000);
    end
  endtask : slot_run

  task set_sel(input logic v);
    if (v) @(posedge lnk_if.ws);
    else @(negedge lnk_if.ws);
    repeat (8) @(negedge core_clk_i);
    select_i = v;
  endtask : set_sel

  task tally_and_finish;
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // =====================================================================
  // scenarios
  task t_start;
    int i;
    for (i = 0; i < 300 && active_o !== 1'b1; i++) @(negedge core_clk_i);
    check(24'(active_o), 24'h000001);
    check(24'(mic_warm), 24'h000000);
    repeat (25) @(negedge core_clk_i);
    check(24'(mic_warm), 24'h000001);
    check(24'(host_warm), 24'h000001);
  endtask : t_start

  task t_density;
    int tbl [5] = '{0, 64, 48, 17, 32};
    foreach (tbl[k]) slot_run(tbl[k], exp_word(tbl[k]), 16);
  endtask : t_density

  task t_select_low;
    set_sel(1'b0);
    slot_run(40, exp_word(40), 16);
    slot_run(5, exp_word(5), 16);
    set_sel(1'b1);
  endtask : t_select_low

  task t_power;
    power_good_i = 1'b0;
    repeat (40) @(negedge core_clk_i);
    check(24'(active_o), 24'h000000);
    check(24'(lnk_if.host_serial_input_line), 24'h000000);
    slot_run(dens, 24'h000000, 1);
    power_good_i = 1'b1;
    t_start();
    slot_run(50, exp_word(50), 16);
  endtask : t_power

  // stop a quarter of the way through the other slot so the data pin is already released
  task t_sleep;
    @(negedge lnk_if.ws);
    repeat (32) @(negedge core_clk_i);
    run_i = 1'b0;
    repeat (200) @(negedge core_clk_i);
    check(24'(active_o), 24'h000000);
    check(24'(lnk_if.mic_data_oe), 24'h000000);
    run_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    check(24'(host_warm), 24'h000000);
    t_start();
    slot_run(20, exp_word(20), 16);
  endtask : t_sleep

  initial
  begin
    #4000000;
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    srst_i = 1'b1;
    mic_srst = 1'b1;
    power_good_i = 1'b1;
    select_i = 1'b1;
    pdm_valid_i = 1'b0;
    run_i = 1'b1;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(negedge core_clk_i);
    srst_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    mic_srst = 1'b0;
    pdm_valid_i = 1'b1;
    t_start();
    t_density();
    t_select_low();
    t_power();
    t_sleep();
    tally_and_finish();
  end
endmodule : test_mic_serial_audio_output
